/* File: logic/serial_sender_pkg.sv */
package serial_sender_pkg;
    // clock rate
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS     = 10;
    // pulse delay before it acts
    localparam int unsigned CLOCK_DELAY_US    = 50;
    localparam int unsigned CLOCK_DELAY_CYC   = (CLOCK_DELAY_US * 1000) / CLK_PERIOD_NS;
    // line rate
    localparam int unsigned BAUD_RATE         = 1050;
    localparam int unsigned BIT_CYC           = CLK_HZ / BAUD_RATE;
    // stop timer slightly under one bit, sample delay about one half bit
    localparam int unsigned STOP_TIMER_CYC    = (BIT_CYC * 15) / 16;
    localparam int unsigned SAMPLE_DELAY_CYC  = BIT_CYC / 2;
    // code levels
    localparam int unsigned MAX_LEVELS        = 8;
    localparam int unsigned DEFAULT_LEVELS    = 8;
    localparam int unsigned FIFO_DEPTH        = 8;
    // reset value of the register: all ones so the line idles at mark
    localparam logic [MAX_LEVELS:0] REG_RESET = 9'h1ff;
    localparam logic [MAX_LEVELS:0] REG_CLEAR = 9'h000;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_SHIFT
    } phase_t;
endpackage

/* File: logic/char_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module char_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
        end
        if (push && !pop)
        begin
            next_count = (AW+1)'(count + 1'b1);
        end
        else if (pop && !push)
        begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage has no reset; only entries written since reset are read out while out_valid is high
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* File: logic/start_stop_serial_sender.sv */
`timescale 1ns/1ns
`default_nettype none
module start_stop_serial_sender #(
    parameter int unsigned LEVELS         = serial_sender_pkg::DEFAULT_LEVELS,
    parameter int unsigned BIT_CYC        = serial_sender_pkg::BIT_CYC,
    parameter int unsigned STOP_TIMER_CYC = serial_sender_pkg::STOP_TIMER_CYC,
    parameter int unsigned SAMPLE_CYC     = serial_sender_pkg::SAMPLE_DELAY_CYC,
    parameter int unsigned FIFO_DEPTH     = serial_sender_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                                   core_clk,
    input  wire logic                                   srst,
    // reader side pins
    input  wire logic                                   char_clock,
    input  wire logic                                   tape_present,
    input  wire logic [serial_sender_pkg::MAX_LEVELS-1:0] reader_level,
    input  wire logic [serial_sender_pkg::MAX_LEVELS-1:0] aux_level,
    input  wire logic                                   osc_on,
    // auxiliary outputs
    output logic                                        sample_pulse,
    output logic                                        start_pulse,
    // modem side
    output logic                                        serial_out
);
    localparam int unsigned ML  = serial_sender_pkg::MAX_LEVELS;
    localparam int unsigned DLY = serial_sender_pkg::CLOCK_DELAY_CYC;
    localparam int unsigned CW  = 32;

    // three-stage pin synchronisers; stage one is read only by stage two
    logic [2:0]    clk_sync;
    logic [2:0]    tape_sync;
    logic [2:0]    osc_sync;
    logic [ML-1:0] lvl_s1;
    logic [ML-1:0] lvl_s2;
    logic [ML-1:0] lvl_s3;
    logic          clk_seen;
    logic          osc_seen;
    logic          tape_level;
    logic          clk_rise;
    logic          osc_rise;
    logic [ML-1:0] mark_level;

    logic          next_clk_seen;
    logic          next_osc_seen;
    logic          next_tape_level;
    logic [ML-1:0] next_mark_level;
    logic [ML-1:0] lvl_differ;

    // seen flags and level bits move only once stages two and three agree
    assign lvl_differ = lvl_s2 ^ lvl_s3;

    always_comb
    begin
        next_clk_seen   = clk_seen;
        next_osc_seen   = osc_seen;
        next_tape_level = tape_level;
        next_mark_level = (lvl_s3 & ~lvl_differ) | (mark_level & lvl_differ);
        if (clk_sync[1] == clk_sync[2])
        begin
            next_clk_seen = clk_sync[2];
        end
        if (osc_sync[1] == osc_sync[2])
        begin
            next_osc_seen = osc_sync[2];
        end
        if (tape_sync[1] == tape_sync[2])
        begin
            next_tape_level = tape_sync[2];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            clk_sync   <= 3'h0;
            tape_sync  <= 3'h0;
            osc_sync   <= 3'h0;
            lvl_s1     <= '0;
            lvl_s2     <= '0;
            lvl_s3     <= '0;
            clk_seen   <= 1'b0;
            osc_seen   <= 1'b0;
            tape_level <= 1'b0;
            mark_level <= '0;
        end
        else
        begin
            clk_sync   <= {clk_sync[1:0], char_clock};
            tape_sync  <= {tape_sync[1:0], tape_present};
            osc_sync   <= {osc_sync[1:0], osc_on};
            lvl_s1     <= reader_level | aux_level;
            lvl_s2     <= lvl_s1;
            lvl_s3     <= lvl_s2;
            clk_seen   <= next_clk_seen;
            osc_seen   <= next_osc_seen;
            tape_level <= next_tape_level;
            mark_level <= next_mark_level;
        end
    end

    assign clk_rise   = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_seen;
    assign osc_rise   = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_seen;

    // character timing
    logic          delay_busy;
    logic [CW-1:0] delay_cnt;
    logic          stop_busy;
    logic [CW-1:0] stop_cnt;
    logic          osc_run;
    logic          samp_busy;
    logic [CW-1:0] samp_cnt;
    logic [CW-1:0] bit_cnt;
    logic          next_delay_busy;
    logic [CW-1:0] next_delay_cnt;
    logic          next_stop_busy;
    logic [CW-1:0] next_stop_cnt;
    logic          next_osc_run;
    logic          next_samp_busy;
    logic [CW-1:0] next_samp_cnt;
    logic [CW-1:0] next_bit_cnt;
    logic          next_sample_pulse;
    logic          next_start_pulse;
    logic          delayed_clk;
    logic          bit_pulse;
    logic          start_set;

    // a new clock pulse during the delay restarts it; pulses are a character apart
    assign delayed_clk = delay_busy && (delay_cnt == CW'(1));
    assign bit_pulse   = osc_run && (bit_cnt == CW'(BIT_CYC - 1));
    // the oscillator-on lead bypasses the tape gate
    assign start_set   = (start_pulse && tape_level) || osc_rise;

    always_comb
    begin
        next_delay_busy   = delay_busy;
        next_delay_cnt    = delay_cnt;
        next_stop_busy    = stop_busy;
        next_stop_cnt     = stop_cnt;
        next_osc_run      = osc_run;
        next_samp_busy    = samp_busy;
        next_samp_cnt     = samp_cnt;
        next_bit_cnt      = bit_cnt;
        next_sample_pulse = 1'b0;
        next_start_pulse  = 1'b0;

        if (clk_rise)
        begin
            next_delay_busy = 1'b1;
            next_delay_cnt  = CW'(DLY);
        end
        else if (delay_busy)
        begin
            next_delay_cnt  = delay_cnt - CW'(1);
            next_delay_busy = (delay_cnt != CW'(1));
        end

        if (delayed_clk)
        begin
            next_stop_busy = 1'b1;
            next_stop_cnt  = CW'(STOP_TIMER_CYC);
        end
        else if (stop_busy)
        begin
            next_stop_cnt = stop_cnt - CW'(1);
            if (stop_cnt == CW'(1))
            begin
                next_stop_busy   = 1'b0;
                next_start_pulse = 1'b1;
            end
        end

        // oscillator counter restarts in phase with its enable; the first pulse
        // falls on the enable edge, well inside the half-bit sample delay
        if (osc_run)
        begin
            next_bit_cnt = bit_pulse ? '0 : bit_cnt + CW'(1);
        end
        else
        begin
            next_bit_cnt = CW'(BIT_CYC - 1);
        end

        // delayed clock clear wins over a start set in the same cycle
        if (delayed_clk)
        begin
            next_osc_run = 1'b0;
        end
        else if (start_set && !osc_run)
        begin
            next_osc_run   = 1'b1;
            next_samp_busy = 1'b1;
            next_samp_cnt  = CW'(SAMPLE_CYC);
        end

        if (samp_busy && !(start_set && !osc_run))
        begin
            next_samp_cnt = samp_cnt - CW'(1);
            if (samp_cnt == CW'(1))
            begin
                next_samp_busy    = 1'b0;
                next_sample_pulse = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            delay_busy   <= 1'b0;
            delay_cnt    <= '0;
            stop_busy    <= 1'b0;
            stop_cnt     <= '0;
            osc_run      <= 1'b0;
            samp_busy    <= 1'b0;
            samp_cnt     <= '0;
            bit_cnt      <= CW'(BIT_CYC - 1);
            sample_pulse <= 1'b0;
            start_pulse  <= 1'b0;
        end
        else
        begin
            delay_busy   <= next_delay_busy;
            delay_cnt    <= next_delay_cnt;
            stop_busy    <= next_stop_busy;
            stop_cnt     <= next_stop_cnt;
            osc_run      <= next_osc_run;
            samp_busy    <= next_samp_busy;
            samp_cnt     <= next_samp_cnt;
            bit_cnt      <= next_bit_cnt;
            sample_pulse <= next_sample_pulse;
            start_pulse  <= next_start_pulse;
        end
    end

    // sampled characters pass a small fifo before loading the register;
    // the register is always free by the time the next sample lands, so the
    // fifo normally holds one word, but it stalls loading if drained late
    logic          fifo_out_valid;
    logic [ML-1:0] fifo_out_data;
    logic          load_ready;

    char_fifo #(
        .WIDTH (ML),
        .DEPTH (FIFO_DEPTH)
    ) u_char_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (sample_pulse),
        .in_ready  (),
        .in_data   (mark_level),
        .out_valid (fifo_out_valid),
        .out_ready (load_ready),
        .out_data  (fifo_out_data)
    );

    // shift register: index 0 is the output element, 1..LEVELS the code levels
    logic [ML:0]   shreg;
    logic [ML:0]   next_shreg;
    logic          cleared;
    logic          next_cleared;
    logic          advance;
    logic          clear_pulse;
    logic [ML:0]   level_mask;

    assign clear_pulse = bit_pulse && samp_busy;
    assign advance     = bit_pulse && !samp_busy;
    // loading never waits on the fill side, so a full fifo still drains
    assign load_ready  = cleared;

    // marks load only into active levels; higher elements never reach the line
    always_comb
    begin
        level_mask = '0;
        for (int i = 1; i <= ML; i++)
        begin
            if (i <= int'(LEVELS))
            begin
                level_mask[i] = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_shreg   = shreg;
        next_cleared = cleared;
        if (clear_pulse)
        begin
            next_shreg   = serial_sender_pkg::REG_CLEAR;
            next_cleared = 1'b1;
        end
        else if (advance)
        begin
            // top active level takes a one, so marks follow the data
            next_shreg   = {1'b1, shreg[ML:1]};
            next_shreg[LEVELS] = 1'b1;
            next_cleared = 1'b0;
        end
        else if (fifo_out_valid && load_ready)
        begin
            next_shreg   = shreg | ({fifo_out_data, 1'b0} & level_mask);
            next_cleared = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            shreg   <= serial_sender_pkg::REG_RESET;
            cleared <= 1'b0;
        end
        else
        begin
            shreg   <= next_shreg;
            cleared <= next_cleared;
        end
    end

    assign serial_out = shreg[0];
endmodule
`default_nettype wire

/* File: test/start_stop_serial_sender_props.sv */
`timescale 1ns/1ns
`default_nettype none
module start_stop_serial_sender_props #(
    parameter int unsigned LEVELS         = 8,
    parameter int unsigned BIT_CYC        = 20,
    parameter int unsigned STOP_TIMER_CYC = 18,
    parameter int unsigned SAMPLE_CYC     = 10,
    parameter int unsigned FIFO_DEPTH     = 8
) (
    // clock and reset
    input wire logic                                       core_clk,
    input wire logic                                       srst,
    // reader side
    input wire logic                                       char_clock,
    input wire logic                                       tape_present,
    input wire logic [serial_sender_pkg::MAX_LEVELS-1:0]   reader_level,
    input wire logic [serial_sender_pkg::MAX_LEVELS-1:0]   aux_level,
    input wire logic                                       osc_on,
    // outputs
    input wire logic                                       sample_pulse,
    input wire logic                                       start_pulse,
    input wire logic                                       serial_out
);
    localparam int S_LO = SAMPLE_CYC;
    localparam int S_HI = SAMPLE_CYC + 8;
    localparam int FR   = (LEVELS + 2) * BIT_CYC + SAMPLE_CYC;
    localparam int D1   = BIT_CYC;
    localparam int DN   = LEVELS * BIT_CYC;
    localparam int DS   = (LEVELS + 1) * BIT_CYC;
    localparam int W_LO = serial_sender_pkg::CLOCK_DELAY_CYC + STOP_TIMER_CYC;
    localparam int W_HI = W_LO + 10;

    // cycles since the clock pin rose and since tape_present last changed
    logic        clk_q;
    logic        tape_q;
    logic [15:0] since_clk;
    logic [3:0]  tape_run;
    always_ff @(posedge core_clk)
    begin
        clk_q <= char_clock;
        tape_q <= tape_present;
        if (srst)
            since_clk <= 16'hffff;
        else if (char_clock && !clk_q)
            since_clk <= 16'h0000;
        else if (since_clk != 16'hffff)
            since_clk <= since_clk + 16'h0001;
        if (srst || tape_present != tape_q)
            tape_run <= 4'h0;
        else if (tape_run != 4'hf)
            tape_run <= tape_run + 4'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_space_hold;
        !serial_out [*4];
    endsequence
    sequence s_gated_start;
        start_pulse && tape_present && tape_run == 4'hf;
    endsequence

    property p_reset_mark;
        @(posedge core_clk) disable iff (1'b0) srst |=> serial_out && !sample_pulse && !start_pulse;
    endproperty
    a_reset_mark: assert property (p_reset_mark) else $error("line not at mark after reset");
    property p_start_time;
        start_pulse |-> since_clk >= W_LO && since_clk <= W_HI;
    endproperty
    a_start_time: assert property (p_start_time) else $error("start pulse off its delay");
    property p_sample_once;
        sample_pulse |=> !sample_pulse [*8];
    endproperty
    a_sample_once: assert property (p_sample_once) else $error("sample pulse repeated");
    property p_osc_start;
        s_gated_start |-> ##[S_LO:S_HI] sample_pulse;
    endproperty
    a_osc_start: assert property (p_osc_start) else $error("no sample after gated start");
    property p_no_tape;
        start_pulse && !tape_present && tape_run == 4'hf && !osc_on |-> not (##[1:FR] (sample_pulse || !serial_out));
    endproperty
    a_no_tape: assert property (p_no_tape) else $error("character sent without tape");
    property p_osc_on;
        $rose(osc_on) |-> ##[S_LO:S_HI] sample_pulse;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator-on did not start");
    property p_start_bit;
        sample_pulse |-> s_space_hold;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit missing");
    property p_first_level;
        sample_pulse |-> ##D1 (serial_out == (reader_level[0] | aux_level[0]));
    endproperty
    a_first_level: assert property (p_first_level) else $error("first level wrong");
    property p_last_level;
        sample_pulse |-> ##DN (serial_out == (reader_level[LEVELS-1] | aux_level[LEVELS-1]));
    endproperty
    a_last_level: assert property (p_last_level) else $error("last level wrong");
    property p_stop;
        sample_pulse |-> ##DS serial_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop bit missing");
    property p_bit_hold;
        (serial_out != $past(serial_out)) |=> $stable(serial_out) [*8];
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("bit shorter than bit time");
endmodule

bind start_stop_serial_sender start_stop_serial_sender_props #(
    .LEVELS(LEVELS), .BIT_CYC(BIT_CYC), .STOP_TIMER_CYC(STOP_TIMER_CYC), .SAMPLE_CYC(SAMPLE_CYC),
    .FIFO_DEPTH(FIFO_DEPTH)
) u_props (.core_clk(core_clk), .srst(srst), .char_clock(char_clock), .tape_present(tape_present),
    .reader_level(reader_level), .aux_level(aux_level), .osc_on(osc_on), .sample_pulse(sample_pulse),
    .start_pulse(start_pulse), .serial_out(serial_out));
`default_nettype wire

/* File: test/modem_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module modem_rx #(
    parameter int unsigned LEVELS  = 8,
    parameter int unsigned BIT_CYC = 20
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // line from the sender
    input  wire logic       line,
    // received character
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_err
);
    logic [7:0] word;
    logic       bad;
    int         k;
    // samples at mid bit, so a few cycles of skew between start edge and bit pulses are tolerated
    initial
    begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_err = 1'b0;
        forever
        begin
            @(posedge core_clk);
            if (srst === 1'b0 && line === 1'b0)
            begin
                word = 8'h00;
                repeat (BIT_CYC / 2) @(posedge core_clk);
                bad = (line !== 1'b0);
                for (k = 0; k < LEVELS; k++)
                begin
                    repeat (BIT_CYC) @(posedge core_clk);
                    word[k] = line;
                end
                repeat (BIT_CYC) @(posedge core_clk);
                bad = bad | (line !== 1'b1);
                rx_data <= word;
                rx_err <= bad;
                rx_valid <= 1'b1;
                @(posedge core_clk);
                rx_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/tb_start_stop_serial_sender.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_start_stop_serial_sender;
    localparam int unsigned LV = 8;
    localparam int unsigned BC = 20;
    logic       core_clk;
    logic       srst;
    logic       char_clock;
    logic       tape_present;
    logic       osc_on;
    logic [7:0] reader_level;
    logic [7:0] aux_level;
    logic       sample_pulse;
    logic       start_pulse;
    logic       serial_out;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_err;
    int         err_total;
    int         n_checks;
    int         n_start;
    int         n_sample;

    start_stop_serial_sender #(.LEVELS(LV), .BIT_CYC(BC), .STOP_TIMER_CYC(18), .SAMPLE_CYC(10), .FIFO_DEPTH(8)) DUT (
        .core_clk(core_clk), .srst(srst), .char_clock(char_clock), .tape_present(tape_present),
        .reader_level(reader_level), .aux_level(aux_level), .osc_on(osc_on), .sample_pulse(sample_pulse),
        .start_pulse(start_pulse), .serial_out(serial_out));
    modem_rx #(.LEVELS(LV), .BIT_CYC(BC)) u_modem (.core_clk(core_clk), .srst(srst), .line(serial_out),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err));

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (start_pulse === 1'b1) n_start++;
        if (sample_pulse === 1'b1) n_sample++;
    end

    task tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_rx;
        int i;
        for (i = 0; i < 6000 && rx_valid !== 1'b1; i++) tick(1);
        check_bit(rx_valid, 1'b1);
    endtask
    // levels stay put through the whole frame, the bound property checks read them late
    task frame_test(input logic [7:0] rd, input logic [7:0] ax);
        n_start = 0;
        n_sample = 0;
        reader_level = rd;
        aux_level = ax;
        char_clock = 1'b1;
        tick(5);
        char_clock = 1'b0;
        wait_rx;
        check_byte(rx_data, rd | ax);
        check_bit(rx_err, 1'b0);
        tick(40);
        check_byte(8'(n_start), 8'h01);
        check_byte(8'(n_sample), 8'h01);
        check_bit(serial_out, 1'b1);
        $display("frame %h done", rd | ax);
    endtask
    task test_no_tape;
        n_start = 0;
        n_sample = 0;
        tape_present = 1'b0;
        tick(20);
        char_clock = 1'b1;
        tick(5);
        char_clock = 1'b0;
        tick(5400);
        check_byte(8'(n_start), 8'h01);
        check_byte(8'(n_sample), 8'h00);
        check_bit(serial_out, 1'b1);
        $display("no tape done");
    endtask
    task test_osc_on(input logic [7:0] rd);
        n_start = 0;
        n_sample = 0;
        reader_level = rd;
        aux_level = 8'h00;
        osc_on = 1'b1;
        tick(5);
        osc_on = 1'b0;
        wait_rx;
        check_byte(rx_data, rd);
        check_byte(8'(n_start), 8'h00);
        check_byte(8'(n_sample), 8'h01);
        tick(40);
        $display("oscillator-on done");
    endtask
    // reset in mid character: the line must go back to mark at once
    task test_mid_reset;
        int i;
        tape_present = 1'b1;
        tick(20);
        char_clock = 1'b1;
        tick(5);
        char_clock = 1'b0;
        for (i = 0; i < 6000 && serial_out !== 1'b0; i++) tick(1);
        check_bit(serial_out, 1'b0);
        tick(30);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        check_bit(serial_out, 1'b1);
        check_bit(start_pulse, 1'b0);
        check_bit(sample_pulse, 1'b0);
        tick(400);
        check_bit(serial_out, 1'b1);
        $display("mid-run reset done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(60000 * 10);
        err_total++;
        $display("watchdog expired");
        results;
    end
    initial
    begin
        core_clk = 1'b0;
        srst = 1'b1;
        char_clock = 1'b0;
        tape_present = 1'b1;
        osc_on = 1'b0;
        reader_level = 8'h00;
        aux_level = 8'h00;
        err_total = 0;
        n_checks = 0;
        repeat (6) @(posedge core_clk);
        #1;
        srst = 1'b0;
        tick(10);
        check_bit(serial_out, 1'b1);
        $display("reset done");
        frame_test(8'ha5, 8'h00);
        frame_test(8'h00, 8'h00);
        frame_test(8'h00, 8'h5a);
        frame_test(8'h81, 8'h7e);
        test_no_tape;
        test_osc_on(8'h3c);
        test_mid_reset;
        results;
    end
endmodule
`default_nettype wire
